// file: src/rtpc_defines.svh
// Function
// - Channel code picks carrier, above 0x62 invalid
// - Channel write restarts synthesizer settling by class
// - Zero length sends header and checksum only
// - Start bit launches packet, self-clears at end
// - Empty buffer after length field aborts with error
// - Flush empties buffer; else restart resends packet
// - Code length bit picks 64 or 32 chips
// - Two-bit data mode picks transmission mode
// - Three-bit power field sets output level
// - Interrupt is any of the low six flags with its enable
// - Oscillator stable flag set at synth start
// - Low voltage follows battery when unit enabled
// - Level flags follow buffer occupancy continuously
// - Underrun or overfill sets error, flush clears
// - Done flag at end, cleared by status read
// - Error flag on ack timeout, read clears
// - Ack receipt may use receive flags instead
`ifndef RTPC_DEFINES_SVH
`define RTPC_DEFINES_SVH
`define RTPC_ADDR_CHANNEL 8'h00
`define RTPC_ADDR_LENGTH 8'h01
`define RTPC_ADDR_CTRL 8'h02
`define RTPC_ADDR_CFG 8'h03
`define RTPC_ADDR_STATUS 8'h04
`define RTPC_ADDR_TXBUF 8'h20
`define RTPC_RST_CHANNEL 7'h28
`define RTPC_RST_LENGTH 8'h00
`define RTPC_RST_CTRL 6'h03
`define RTPC_RST_CFG 6'h0D
`define RTPC_CHAN_MAX 7'h62
`define RTPC_BIT_GO 7
`define RTPC_BIT_FLUSH 6
`define RTPC_LVL_NOT_FULL 15
`define RTPC_LVL_HALF 8
`define RTPC_CLK_MHZ 200
`define RTPC_SETTLE_FAST_US 100
`define RTPC_SETTLE_MED_US 180
`define RTPC_SETTLE_SLOW_US 270
`define RTPC_CYC(us) ((us) * `RTPC_CLK_MHZ)
`endif

// file: src/rtpc_pkg.sv
package rtpc_pkg;
  typedef enum logic [1:0] {RTPC_MODE_FSK, RTPC_MODE_EIGHT, RTPC_MODE_DOUBLE, RTPC_MODE_SINGLE} rtpc_mode_t;
  typedef enum logic [1:0] {RTPC_SETTLE_FAST, RTPC_SETTLE_MED, RTPC_SETTLE_SLOW} rtpc_class_t;
  typedef enum {RTPC_IDLE, RTPC_SYNTH, RTPC_HEADER, RTPC_PAYLOAD, RTPC_TRAILER, RTPC_ACK} rtpc_state_t;
endpackage : rtpc_pkg

// file: src/rtpc_tx_control.sv
// Strobed register access was chosen for this implementation.
`include "rtpc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Transmit control of the packet radio
// ----------------------------------------
// Holds channel, length, command and mode registers, the
// sixteen-byte transmit buffer, the packet sequence and the
// transmit status flags with their interrupt. Framing and the
// radio itself sit on the link side of the ports.
module rtpc_tx_control #(
  parameter int DEPTH = 16,
  parameter int SETTLE_FAST = `RTPC_CYC(`RTPC_SETTLE_FAST_US),
  parameter int SETTLE_MED = `RTPC_CYC(`RTPC_SETTLE_MED_US),
  parameter int SETTLE_SLOW = `RTPC_CYC(`RTPC_SETTLE_SLOW_US),
  parameter int ACK_TIMEOUT = 256
) (
  // Clock and reset
  // Reset is asynchronous in assertion
  input wire logic clock,
  input wire logic resetn,
  // Register port
  // Strobes are one cycle wide and never high together
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Radio link side (same clock)
  // Strobes from the link are one-cycle pulses
  input wire logic transactionMode,
  input wire logic hdrSent,
  input wire logic trailerSent,
  input wire logic byteTaken,
  input wire logic ackValid,
  input wire logic ackBad,
  input wire logic oscSettled,
  input wire logic pmuEnable,
  // Battery comparator, from outside the domain
  // Asynchronous to the clock: synchronised before use
  input wire logic batteryLow,
  // Radio control outputs
  // Data outputs come from registers or the storage array
  output logic [6:0] channelOut,
  output logic [1:0] dataMode,
  output logic longCode,
  output logic [2:0] powerLevel,
  output logic synthBusy,
  output logic txActive,
  output logic payloadPhase,
  output logic [7:0] txByte,
  output logic txByteValid,
  output logic ackToRxFlags,
  output logic irq
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  localparam int AW = $clog2(DEPTH);
  // Pointer width follows the buffer depth; the count
  // and sent tallies need one more bit to hold a full
  // buffer without wrapping back to zero
  // Software copies of the control registers
  logic [6:0] channel_r;
  logic [7:0] length_r;
  logic [5:0] ctrl_r;
  logic [5:0] cfg_r;
  logic go_r;
  // Transmit store and its bookkeeping
  logic [7:0] mem_r [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic [AW:0] sent_r;
  logic [7:0] owed_r;
  // Shared down-counter: settling first, then ack wait
  // A channel write during the ack wait reloads it with the
  // settle count, so the two uses can overlap
  logic [31:0] timer_r;
  rtpc_pkg::rtpc_state_t state_r;
  // Sticky status flags
  logic oscFlag_r;
  logic bufErr_r;
  logic doneFlag_r;
  logic errFlag_r;
  // Battery comparator synchroniser stages
  logic batSync1_r;
  logic batSync2_r;

  // Decodes
  // Buffer pushes only when room is left; an extra byte
  // into a full buffer is dropped and flagged instead
  // Pops need a byte on hand and a byte still owed, so a
  // stale take from the link cannot drain past the packet
  wire logic wrChan = regWr && regAddr == `RTPC_ADDR_CHANNEL;
  wire logic wrCtrl = regWr && regAddr == `RTPC_ADDR_CTRL;
  wire logic wrBuf = regWr && regAddr == `RTPC_ADDR_TXBUF;
  wire logic rdStat = regRd && regAddr == `RTPC_ADDR_STATUS;
  wire logic flush = wrCtrl && regWdata[`RTPC_BIT_FLUSH];
  wire logic full = count_r == (AW+1)'(DEPTH);
  wire logic empty = count_r == '0;
  wire logic pop = state_r == rtpc_pkg::RTPC_PAYLOAD && byteTaken && !empty && owed_r != 8'h00;
  wire logic push = wrBuf && !full;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Software settings; no range check, host keeps channel legal
  // Unmapped addresses, the buffer port included, fall
  // through here without touching any setting
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_r <= `RTPC_RST_CHANNEL;
      length_r <= `RTPC_RST_LENGTH;
      ctrl_r <= `RTPC_RST_CTRL;
      cfg_r <= `RTPC_RST_CFG;
    end else if (regWr) begin
      unique case (regAddr)
        `RTPC_ADDR_CHANNEL: channel_r <= regWdata[6:0];
        `RTPC_ADDR_LENGTH: length_r <= regWdata;
        `RTPC_ADDR_CTRL: ctrl_r <= regWdata[5:0];
        `RTPC_ADDR_CFG: cfg_r <= regWdata[5:0];
        default: ;
      endcase
    end
  end

  // Radio settings go straight out; the long code is masked
  // in the frequency-shift mode, where spreading has no use
  assign channelOut = channel_r;
  assign longCode = cfg_r[5] && cfg_r[4:3] != 2'b00;
  assign dataMode = cfg_r[4:3];
  assign powerLevel = cfg_r[2:0];

  // ----------------------------------------
  // Settling class
  // ----------------------------------------
  // Classes repeat in a period of six codes up to 72; above that only 96 is fast
  function automatic rtpc_pkg::rtpc_class_t chanClass(input logic [6:0] ch);
    logic [2:0] m;
    // Multiples of three are fast up to 72; above that the
    // fast band stops, and only 96 is fast again
    // Outside the fast set, even codes are medium and odd
    // codes are slow
    m = 3'(ch % 7'd3);
    if (ch == 7'd96 || (m == 3'd0 && ch <= 7'd72)) chanClass = rtpc_pkg::RTPC_SETTLE_FAST;
    else if (ch[0] == 1'b0) chanClass = rtpc_pkg::RTPC_SETTLE_MED;
    else chanClass = rtpc_pkg::RTPC_SETTLE_SLOW;
  endfunction : chanClass

  // Cycle count for the class of a channel; codes above the
  // valid range still get the timing of their parity
  function automatic logic [31:0] settleCycles(input logic [6:0] ch);
    unique case (chanClass(ch))
      rtpc_pkg::RTPC_SETTLE_FAST: settleCycles = 32'(SETTLE_FAST);
      rtpc_pkg::RTPC_SETTLE_MED: settleCycles = 32'(SETTLE_MED);
      default: settleCycles = 32'(SETTLE_SLOW);
    endcase
  endfunction : settleCycles

  // ----------------------------------------
  // Transmit sequence
  // ----------------------------------------
  // Settling, header, payload, trailer, optional acknowledgement wait
  // One packet at a time; a start while busy is ignored
  // and the start bit reads back as set until the end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r <= rtpc_pkg::RTPC_IDLE;
      go_r <= 1'b0;
      timer_r <= '0;
      owed_r <= 8'h00;
    end else begin
      if (wrChan) timer_r <= settleCycles(regWdata[6:0]);
      else if (timer_r != '0) timer_r <= timer_r - 32'd1;
      // Packet sequence
      unique case (state_r)
        rtpc_pkg::RTPC_IDLE: begin
          // Length is latched at launch, so a later length write
          // only affects the next packet
          if (wrCtrl && regWdata[`RTPC_BIT_GO]) begin
            go_r <= 1'b1;
            owed_r <= length_r;
            state_r <= rtpc_pkg::RTPC_SYNTH;
          end
        end
        rtpc_pkg::RTPC_SYNTH: begin
          // A channel write in the same cycle restarts settling
          if (timer_r == '0 && !wrChan) state_r <= rtpc_pkg::RTPC_HEADER;
        end
        rtpc_pkg::RTPC_HEADER: begin
          // Length field is out: payload, trailer, or abort
          // when the buffer has nothing to give
          if (hdrSent) begin
            if (owed_r == 8'h00) state_r <= rtpc_pkg::RTPC_TRAILER;
            else if (empty) begin
              state_r <= rtpc_pkg::RTPC_IDLE;
              go_r <= 1'b0;
            end else state_r <= rtpc_pkg::RTPC_PAYLOAD;
          end
        end
        rtpc_pkg::RTPC_PAYLOAD: begin
          // Count down owed bytes; the last pop moves on
          if (pop) begin
            owed_r <= owed_r - 8'h01;
            if (owed_r == 8'h01) state_r <= rtpc_pkg::RTPC_TRAILER;
          end
        end
        rtpc_pkg::RTPC_TRAILER: begin
          // Transaction mode waits for an ack with a bounded timer
          if (trailerSent) begin
            if (transactionMode) begin
              state_r <= rtpc_pkg::RTPC_ACK;
              timer_r <= 32'(ACK_TIMEOUT);
            end else begin
              state_r <= rtpc_pkg::RTPC_IDLE;
              go_r <= 1'b0;
            end
          end
        end
        rtpc_pkg::RTPC_ACK: begin
          // Either a good ack or the timeout ends the wait
          if (ackValid || timer_r == '0) begin
            state_r <= rtpc_pkg::RTPC_IDLE;
            go_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Sequence status for the radio side; a byte is only
  // offered while the payload phase has one on hand
  assign synthBusy = timer_r != '0;
  assign txActive = go_r;
  assign payloadPhase = state_r == rtpc_pkg::RTPC_PAYLOAD;
  assign txByteValid = payloadPhase && !empty;
  assign ackToRxFlags = state_r == rtpc_pkg::RTPC_ACK && ackValid;

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  // Flush rewinds the buffer; a packet sent without flush is kept
  // for resend by remembering how many bytes left since last start
  // Flush takes priority over both push and pop
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      sent_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
      sent_r <= '0;
    end else if (state_r == rtpc_pkg::RTPC_IDLE && wrCtrl && regWdata[`RTPC_BIT_GO]) begin
      // Start without a flush: step back over what the last
      // packet took, so the same bytes go out again; this
      // only holds while nothing was pushed in between
      rdPtr_r <= rdPtr_r - AW'(sent_r);
      count_r <= count_r + sent_r;
      sent_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + AW'(1);
      if (pop) begin
        rdPtr_r <= rdPtr_r + AW'(1);
        sent_r <= sent_r + (AW+1)'(1);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage, one entry per write
  // No reset: contents are don't-care until written
  always_ff @(posedge clock) begin
    if (push) mem_r[wrPtr_r] <= regWdata;
  end

  // Head of the buffer, valid while txByteValid is high
  assign txByte = mem_r[rdPtr_r];

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Battery level crosses in through two stages
  // Only the second stage is read by the flag logic
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      batSync1_r <= 1'b0;
      batSync2_r <= 1'b0;
    end else begin
      batSync1_r <= batteryLow;
      batSync2_r <= batSync1_r;
    end
  end

  // Oscillator flag sticks until reset
  // Only looked at during synth start, as the crystal
  // is known stable from then on
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) oscFlag_r <= 1'b0;
    else if (oscSettled && state_r == rtpc_pkg::RTPC_SYNTH) oscFlag_r <= 1'b1;
  end

  // Buffer error: only flush clears, but a new event wins over it
  // Underrun is seen at the end of the length field and also
  // during the payload, should the buffer run dry mid-packet
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) bufErr_r <= 1'b0;
    else if ((wrBuf && full) || (payloadPhase && empty && owed_r != 8'h00)
             || (state_r == rtpc_pkg::RTPC_HEADER && hdrSent && empty && owed_r != 8'h00)) bufErr_r <= 1'b1;
    else if (flush) bufErr_r <= 1'b0;
  end

  // Done and error flags: set wins over the read that clears
  // A timeout raises both flags in the same cycle, so the
  // host never sees error without done
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      doneFlag_r <= 1'b0;
      errFlag_r <= 1'b0;
    end else begin
      if ((state_r == rtpc_pkg::RTPC_TRAILER && trailerSent && !transactionMode)
          || (state_r == rtpc_pkg::RTPC_ACK && !ackValid && timer_r == '0)) doneFlag_r <= 1'b1;
      else if (rdStat) doneFlag_r <= 1'b0;
      if (state_r == rtpc_pkg::RTPC_ACK && !ackValid && timer_r == '0) errFlag_r <= 1'b1;
      else if (rdStat) errFlag_r <= 1'b0;
    end
  end

  // Status bits; level flags are live from occupancy
  // The three level flags need no storage: they follow
  // the count directly
  logic [7:0] status;
  always_comb begin
    status[7] = oscFlag_r;
    status[6] = pmuEnable && batSync2_r;
    status[5] = count_r <= (AW+1)'(`RTPC_LVL_NOT_FULL);
    status[4] = count_r <= (AW+1)'(`RTPC_LVL_HALF);
    status[3] = empty;
    status[2] = bufErr_r;
    status[1] = doneFlag_r;
    status[0] = errFlag_r;
  end

  // Interrupt: the two top flags have no enable here
  // Enables sit in the low six control bits, matching the
  // low six status bits one to one
  assign irq = |(status[5:0] & ctrl_r);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data one cycle after the strobe; unmapped reads give zero
  // Reads have no side effect except the status read, which
  // clears the done and error flags after this cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) regRdata <= 8'h00;
    else if (regRd) begin
      unique case (regAddr)
        `RTPC_ADDR_CHANNEL: regRdata <= {1'b0, channel_r};
        `RTPC_ADDR_LENGTH: regRdata <= length_r;
        `RTPC_ADDR_CTRL: regRdata <= {go_r, 1'b0, ctrl_r};
        `RTPC_ADDR_CFG: regRdata <= {2'b00, cfg_r};
        `RTPC_ADDR_STATUS: regRdata <= status;
        default: regRdata <= 8'h00;
      endcase
    end else regRdata <= 8'h00;
  end

endmodule : rtpc_tx_control
`default_nettype wire

// file: tb/rtpc_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtpc_link_model (
  // Clock, reset, bench controls
  input wire logic clock,
  input wire logic resetn,
  input wire logic slow,
  input wire logic ackOn,
  input wire logic [7:0] pktLen,
  // Block side
  input wire logic transactionMode,
  input wire logic synthBusy,
  input wire logic txActive,
  input wire logic txByteValid,
  input wire logic [7:0] txByte,
  output logic hdrSent,
  output logic trailerSent,
  output logic byteTaken,
  output logic ackValid,
  output logic oscSettled
);
  // Captured payload, read by the bench
  logic [7:0] got [0:63];
  int nGot;
  int n;
  // One frame per launch; slow mode delays the header and spaces the byte takes
  initial begin
    {hdrSent, trailerSent, byteTaken, ackValid} = 4'h0;
    oscSettled = 1'b1;
    nGot = 0;
    forever begin
      @(posedge clock);
      if (resetn && txActive && !synthBusy) begin
        repeat (slow ? 3 : 0) @(posedge clock);
        hdrSent <= 1'b1;
        @(posedge clock);
        hdrSent <= 1'b0;
        n = 0;
        // Zero length skips straight to the trailer
        for (int t = 0; t < 200 && n < pktLen && txActive; t++) begin
          @(posedge clock);
          if (byteTaken) byteTaken <= 1'b0;
          else if (txByteValid && !(slow && t[1])) begin
            got[nGot] = txByte;
            nGot++;
            n++;
            byteTaken <= 1'b1;
          end
        end
        @(posedge clock);
        byteTaken <= 1'b0;
        if (txActive) begin
          trailerSent <= 1'b1;
          @(posedge clock);
          trailerSent <= 1'b0;
          if (transactionMode && ackOn) begin
            @(posedge clock);
            ackValid <= 1'b1;
            @(posedge clock);
            ackValid <= 1'b0;
          end
        end
        // Hold off a relaunch while an ack wait runs
        for (int w = 0; w < 100 && txActive; w++) @(posedge clock);
      end
    end
  end
endmodule : rtpc_link_model
`default_nettype wire

// file: tb/rtpc_tx_control_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module rtpc_tx_control_props (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  // Radio side
  input wire logic transactionMode,
  input wire logic trailerSent,
  input wire logic [6:0] channelOut,
  input wire logic [1:0] dataMode,
  input wire logic longCode,
  input wire logic [2:0] powerLevel,
  input wire logic synthBusy,
  input wire logic txActive,
  input wire logic payloadPhase,
  input wire logic ackToRxFlags
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Write decodes shared by the properties
  logic chWr, cfgWr, ctlWr;
  assign chWr = regWr && regAddr == 8'h00;
  assign cfgWr = regWr && regAddr == 8'h03;
  assign ctlWr = regWr && regAddr == 8'h02;
  chk_chan_follow: assert property (chWr |=> {1'b0, channelOut} == ($past(regWdata) & 8'h7F))
    else $error("channel output missed write");
  chk_mode_follow: assert property (cfgWr |=> dataMode == 2'($past(regWdata) >> 3))
    else $error("data mode missed write");
  chk_power_follow: assert property (cfgWr |=> powerLevel == 3'($past(regWdata)))
    else $error("power level missed write");
  chk_long_fsk: assert property (dataMode == 2'b00 |-> !longCode)
    else $error("long code active in fsk mode");
  chk_synth_restart: assert property (chWr |=> synthBusy)
    else $error("channel write did not restart settling");
  chk_go_launch: assert property (ctlWr && regWdata[7] |=> txActive)
    else $error("start bit did not launch");
  chk_go_zero: assert property (ctlWr && !regWdata[7] && !txActive |=> !txActive)
    else $error("zero start bit launched");
  chk_go_end: assert property (txActive && trailerSent && !transactionMode |=> !txActive)
    else $error("start bit did not self clear");
  chk_ack_ends: assert property (ackToRxFlags |=> !txActive)
    else $error("ack receipt did not end transmit");
  chk_payload_active: assert property (payloadPhase |-> txActive)
    else $error("payload phase without start bit");
endmodule : rtpc_tx_control_props
bind rtpc_tx_control rtpc_tx_control_props u_props (.clock(clock), .resetn(resetn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .transactionMode(transactionMode), .trailerSent(trailerSent),
  .channelOut(channelOut), .dataMode(dataMode), .longCode(longCode), .powerLevel(powerLevel),
  .synthBusy(synthBusy), .txActive(txActive), .payloadPhase(payloadPhase), .ackToRxFlags(ackToRxFlags));
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock, resetn, regWr, regRd, transactionMode, pmuEnable, batteryLow, slow, ackOn;
  logic [7:0] regAddr, regWdata, regRdata, txByte, pktLen;
  logic hdrSent, trailerSent, byteTaken, ackValid, oscSettled, txByteValid, synthBusy, txActive;
  logic longCode, irq;
  logic [6:0] channelOut;
  logic [1:0] dataMode;
  logic [2:0] powerLevel;
  int errCount, nCompared;
  // Short settle and ack counts keep the run brief
  rtpc_tx_control #(.SETTLE_FAST(4), .SETTLE_MED(6), .SETTLE_SLOW(8), .ACK_TIMEOUT(16)) DUT (
    .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .transactionMode(transactionMode), .hdrSent(hdrSent), .trailerSent(trailerSent),
    .byteTaken(byteTaken), .ackValid(ackValid), .ackBad(1'b0), .oscSettled(oscSettled),
    .pmuEnable(pmuEnable), .batteryLow(batteryLow), .channelOut(channelOut), .dataMode(dataMode),
    .longCode(longCode), .powerLevel(powerLevel), .synthBusy(synthBusy), .txActive(txActive),
    .payloadPhase(), .txByte(txByte), .txByteValid(txByteValid), .ackToRxFlags(), .irq(irq));
  rtpc_link_model link (.clock(clock), .resetn(resetn), .slow(slow), .ackOn(ackOn), .pktLen(pktLen),
    .transactionMode(transactionMode), .synthBusy(synthBusy), .txActive(txActive),
    .txByteValid(txByteValid), .txByte(txByte), .hdrSent(hdrSent), .trailerSent(trailerSent),
    .byteTaken(byteTaken), .ackValid(ackValid), .oscSettled(oscSettled));
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    nCompared++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdChk
  task automatic wrapUp();
    $display("Compared %0d, mismatches %0d", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrapUp
  // Launch one packet and wait, bounded, for the start bit to drop
  task automatic send(input logic [7:0] len, input logic tm);
    int i;
    transactionMode <= tm;
    pktLen = len;
    wr(8'h00, 8'h30);
    wr(8'h01, len);
    wr(8'h02, 8'h83);
    for (i = 0; i < 3000 && txActive !== 1'b0; i++) @(posedge clock);
    #1;
    if (i == 3000) begin
      errCount++;
      $display("CHECK FAILED at %0t: transmit hang", $time);
      wrapUp();
    end
  endtask : send
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tReset();
    logic [7:0] a [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10};
    logic [7:0] e [6] = '{8'h28, 8'h00, 8'h03, 8'h0D, 8'h38, 8'h00};
    for (int i = 0; i < 6; i++) rdChk(a[i], e[i]);
    chk({7'h0, irq}, 8'h00);
  endtask : tReset
  task automatic tCfg();
    logic [7:0] v;
    for (int m = 0; m < 4; m++) begin
      v = {2'b00, 1'b1, 2'(m), 3'(2 * m + 1)};
      wr(8'h03, v);
      chk({2'b00, longCode, dataMode, powerLevel}, {2'b00, m != 0, 2'(m), 3'(2 * m + 1)});
      rdChk(8'h03, v);
    end
  endtask : tCfg
  // Settle length per channel class
  task automatic tSettle();
    logic [7:0] ch [4] = '{8'h48, 8'h4B, 8'h4E, 8'h60};
    logic [7:0] n [4] = '{8'h04, 8'h08, 8'h06, 8'h04};
    int i;
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, ch[k]);
      for (i = 0; i < 100 && synthBusy; i++) begin
        @(posedge clock);
        #1;
      end
      chk(8'(i), n[k]);
    end
  endtask : tSettle
  // Twenty bytes, four written after the start
  task automatic tLong();
    int i;
    wr(8'h02, 8'h43);
    for (i = 0; i < 16; i++) wr(8'h20, 8'(i));
    pktLen = 8'h14;
    wr(8'h01, 8'h14);
    wr(8'h02, 8'h83);
    repeat (8) @(posedge clock);
    for (i = 16; i < 20; i++) wr(8'h20, 8'(i));
    for (i = 0; i < 3000 && txActive !== 1'b0; i++) @(posedge clock);
    #1;
    if (i == 3000) begin
      errCount++;
      $display("CHECK FAILED at %0t: long packet hang", $time);
      wrapUp();
    end
    for (i = 0; i < 20; i++) chk(link.got[6 + i], 8'(i));
    rdChk(8'h04, 8'hBA);
  endtask : tLong
  task automatic tSend();
    wr(8'h02, 8'h43);
    for (int i = 0; i < 3; i++) wr(8'h20, 8'hA0 + 8'(i));
    rdChk(8'h04, 8'h30);
    slow = 1'b1;
    send(8'h03, 1'b0);
    chk({7'h0, irq}, 8'h01);
    rdChk(8'h04, 8'hBA);
    rdChk(8'h04, 8'hB8);
    chk({7'h0, irq}, 8'h00);
    slow = 1'b0;
    send(8'h03, 1'b0);
    rdChk(8'h04, 8'hBA);
    for (int i = 0; i < 6; i++) chk(link.got[i], 8'hA0 + 8'(i % 3));
  endtask : tSend
  task automatic tUnder();
    logic [7:0] d;
    wr(8'h02, 8'h43);
    send(8'h02, 1'b0);
    rd(8'h04, d);
    chk(d & 8'hFD, 8'hBC);
    wr(8'h02, 8'h43);
    rdChk(8'h04, 8'hB8);
  endtask : tUnder
  task automatic tFill();
    wr(8'h02, 8'h23);
    chk({7'h0, irq}, 8'h01);
    for (int i = 0; i < 16; i++) wr(8'h20, 8'(i));
    rdChk(8'h04, 8'h80);
    chk({7'h0, irq}, 8'h00);
    wr(8'h20, 8'hFF);
    rdChk(8'h04, 8'h84);
    wr(8'h02, 8'h43);
    rdChk(8'h04, 8'hB8);
  endtask : tFill
  task automatic tXact();
    logic [7:0] d;
    send(8'h00, 1'b1);
    rdChk(8'h04, 8'hBB);
    ackOn = 1'b1;
    send(8'h00, 1'b1);
    rd(8'h04, d);
    chk(d & 8'hFD, 8'hB8);
    rdChk(8'h04, 8'hB8);
    chk(8'(link.nGot), 8'h06);
    transactionMode <= 1'b0;
  endtask : tXact
  task automatic tLv();
    pmuEnable <= 1'b1;
    batteryLow <= 1'b1;
    repeat (4) @(posedge clock);
    rdChk(8'h04, 8'hF8);
    pmuEnable <= 1'b0;
    repeat (2) @(posedge clock);
    rdChk(8'h04, 8'hB8);
  endtask : tLv
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Main sequence
  initial begin
    {resetn, regWr, regRd, transactionMode, pmuEnable, batteryLow, slow, ackOn} = 8'h00;
    {regAddr, regWdata, pktLen} = 24'h000000;
    errCount = 0;
    nCompared = 0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    tReset();
    tCfg();
    tSettle();
    tSend();
    tUnder();
    tFill();
    tXact();
    tLong();
    tLv();
    wrapUp();
  end
endmodule : tb
`default_nettype wire
